//--- src/fep_rx_map.vh
// constants, codes and timing counts of the 100BASE-TX receive pcs
`ifndef FEP_RX_MAP_VH
`define FEP_RX_MAP_VH

// ************************************************
// control code-groups
// ************************************************
`define FEP_SYM_IDLE     5'h1F
`define FEP_SYM_T        5'h0D
`define FEP_SYM_R        5'h07
`define FEP_JK_PAIR      10'h311
`define FEP_NIB_PREAMBLE 4'h5
`define FEP_NIB_BADSSD   4'hE

// ************************************************
// pcs configuration bit positions
// ************************************************
`define FEP_CFG_FORCE_SD 1
`define FEP_CFG_LOCK_REQ 8

// ************************************************
// sequence generator
// ************************************************
`define FEP_LFSR_W       11
`define FEP_TAP_A        10
`define FEP_TAP_B        8

// ************************************************
// bit counts
// ************************************************
`define FEP_LOCK_IDLES   12
`define FEP_LOCK_BITS    (`FEP_LOCK_IDLES * 5)
`define FEP_IDLE_BITS    58
`define FEP_TWO_IDLE     10
`define FEP_SSD_TAIL     7

// ************************************************
// timing
// ************************************************
`define FEP_CLK_MHZ      40
`define FEP_HOLD_US      722
`define FEP_LINK_US      395
`define FEP_HOLD_CYC     (`FEP_HOLD_US * `FEP_CLK_MHZ)
`define FEP_LINK_CYC     (`FEP_LINK_US * `FEP_CLK_MHZ)

`endif

//--- src/fep_descrambler.v
// self-synchronising descrambler with idle hold timer
`timescale 1ns/1ps
`default_nettype none
`include "fep_rx_map.vh"

module fep_descrambler #(
  parameter [15:0] HOLD_CYC = `FEP_HOLD_CYC
) (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  // scrambled bit stream
  input  wire        bit_v_i,
  input  wire        sd_i,
  input  wire        bypass_i,
  // descrambled bit stream
  output reg         ud_o,
  output reg         ud_v_o,
  output reg         locked_o
);

  // ************************************************
  // state
  // ************************************************
  reg  [`FEP_LFSR_W-1:0] lfsr_q;  // local sequence generator
  reg  [6:0]             run_q;   // consecutive ones seen
  reg  [15:0]            hold_q;  // hold countdown
  wire                   seq_bit; // next sequence bit
  wire                   ud_bit;  // descrambled bit

  assign seq_bit = lfsr_q[`FEP_TAP_A] ^ lfsr_q[`FEP_TAP_B];
  assign ud_bit  = sd_i ^ seq_bit;

  // ************************************************
  // lock, hold timer and output
  // ************************************************
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      lfsr_q   <= {`FEP_LFSR_W{1'b0}};
      run_q    <= 7'h00;
      hold_q   <= 16'h0000;
      locked_o <= 1'b0;
      ud_o     <= 1'b0;
      ud_v_o   <= 1'b0;
    end else begin
      ud_v_o <= bit_v_i & (bypass_i | locked_o);
      if (bit_v_i) begin
        ud_o <= bypass_i ? sd_i : ud_bit;
      end
      if (locked_o && hold_q == 16'h0001) begin
        // hold expired: drop lock, clear all state
        locked_o <= 1'b0;
        lfsr_q   <= {`FEP_LFSR_W{1'b0}};
        run_q    <= 7'h00;
        hold_q   <= 16'h0000;
      end else if (bit_v_i) begin
        if (ud_bit) begin
          run_q <= run_q + 7'h01;
        end else begin
          run_q <= 7'h00;
        end
        if (!locked_o) begin
          // idle on line: sequence bit is inverted input
          lfsr_q <= {lfsr_q[`FEP_LFSR_W-2:0], ~sd_i};
          if (ud_bit && {25'h0000000, run_q} == `FEP_LOCK_BITS - 1) begin
            locked_o <= 1'b1;
            hold_q   <= HOLD_CYC;
            run_q    <= 7'h00;
          end
        end else begin
          // closed loop once locked
          lfsr_q <= {lfsr_q[`FEP_LFSR_W-2:0], seq_bit};
          hold_q <= hold_q - 16'h0001;
          if (ud_bit && {25'h0000000, run_q} == `FEP_IDLE_BITS - 1) begin
            hold_q <= HOLD_CYC;
            run_q  <= 7'h00;
          end
        end
      end else if (locked_o) begin
        hold_q <= hold_q - 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

//--- src/fep_rx_pcs.v
// 100BASE-TX receive pcs: nrzi, descramble, align, decode, link monitor
`timescale 1ns/1ps
`default_nettype none
`include "fep_rx_map.vh"

module fep_rx_pcs #(
  parameter [15:0] HOLD_CYC = `FEP_HOLD_CYC,
  parameter [15:0] LINK_CYC = `FEP_LINK_CYC
) (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  // recovered line clock and nrzi data
  input  wire        rx_line_clk_i,
  input  wire        rx_line_data_i,
  input  wire        signal_detect_i,
  // configuration
  input  wire [15:0] pcs_config_register_i,
  input  wire        descr_bypass_i,
  input  wire        dec_bypass_i,
  input  wire        rx_bypass_i,
  // nibble side towards the mac
  output reg  [3:0]  rx_nib_o,
  output reg         rx_nib_v_o,
  output reg         rx_dv_o,
  output reg         rx_er_o,
  output reg  [4:0]  rx_sym_o,
  output reg         rx_sym_v_o,
  // status
  output reg  [15:0] false_carrier_cnt_o,
  output reg         bad_ssd_rpt_o,
  output wire        descr_locked_o,
  output reg         link_up_o,
  output wire        tx_pcs_en_o,
  output wire        rx_pcs_en_o
);

  // ************************************************
  // aligner states
  // ************************************************
  localparam [2:0] ST_WAIT = 3'h0; // need two idles
  localparam [2:0] ST_IDLE = 3'h1; // line idle
  localparam [2:0] ST_SSD  = 3'h2; // checking start pair
  localparam [2:0] ST_PKT  = 3'h3; // decoding packet
  localparam [2:0] ST_BAD  = 3'h4; // bad start of stream

  // ************************************************
  // 5b to 4b table, msb flags a non-data code
  // ************************************************
  function [4:0] fep_dec;
    input [4:0] s;
    begin
      case (s)
        5'h1E:   fep_dec = 5'h00;
        5'h09:   fep_dec = 5'h01;
        5'h14:   fep_dec = 5'h02;
        5'h15:   fep_dec = 5'h03;
        5'h0A:   fep_dec = 5'h04;
        5'h0B:   fep_dec = 5'h05;
        5'h0E:   fep_dec = 5'h06;
        5'h0F:   fep_dec = 5'h07;
        5'h12:   fep_dec = 5'h08;
        5'h13:   fep_dec = 5'h09;
        5'h16:   fep_dec = 5'h0A;
        5'h17:   fep_dec = 5'h0B;
        5'h1A:   fep_dec = 5'h0C;
        5'h1B:   fep_dec = 5'h0D;
        5'h1C:   fep_dec = 5'h0E;
        5'h1D:   fep_dec = 5'h0F;
        default: fep_dec = 5'h10; // control or invalid
      endcase
    end
  endfunction

  // ************************************************
  // declarations
  // ************************************************
  reg        clk_s1_q;   // line clock sync stage 1
  reg        clk_s2_q;   // line clock sync stage 2
  reg        clk_s3_q;   // edge detect history
  reg        dat_s1_q;   // line data sync stage 1
  reg        dat_s2_q;   // line data sync stage 2
  reg        sd_s1_q;    // signal detect sync 1
  reg        sd_s2_q;    // signal detect sync 2
  reg        nrzi_q;     // previous nrzi level
  reg        nrz_q;      // converted nrz bit
  reg        nrz_v_q;    // one bit per line edge
  reg  [9:0] sh_q;       // last ten aligner bits
  reg  [3:0] ones_q;     // saturating run of ones
  reg  [2:0] st_q;       // aligner state
  reg  [2:0] cnt_q;      // bits since first zero
  reg  [2:0] ph_q;       // symbol phase 0..4
  reg        t_seen_q;   // t received, r expected
  reg        idle1_q;    // previous symbol was idle
  reg        pre2_q;     // second preamble nibble due
  reg [15:0] link_cnt_q; // signal detect qualify
  wire       edge_w;     // rising line clock edge
  wire       ud_w;       // descrambled bit
  wire       ud_v_w;     // descrambled bit valid
  wire       al_bit;     // aligner input bit
  wire       al_v;       // aligner input valid
  wire [9:0] sh_n;       // shift register incl. new bit
  wire [4:0] sym_n;      // symbol ending at new bit
  wire [4:0] dec_n;      // decoded symbol
  wire       sym_idle;   // symbol is idle
  wire       byp_dsc;    // descrambler bypassed
  wire       byp_dec;    // decoder bypassed
  wire       sd_eff;     // effective signal detect
  wire       lock_ok;    // lock term for link entry

  // ************************************************
  // synchronisers and line clock edge
  // ************************************************
  // the line clock is sampled; stage 1 feeds only stage 2
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      dat_s1_q <= 1'b0;
      dat_s2_q <= 1'b0;
      sd_s1_q  <= 1'b0;
      sd_s2_q  <= 1'b0;
    end else begin
      clk_s1_q <= rx_line_clk_i;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      dat_s1_q <= rx_line_data_i;
      dat_s2_q <= dat_s1_q;
      sd_s1_q  <= signal_detect_i;
      sd_s2_q  <= sd_s1_q;
    end
  end

  assign edge_w = clk_s2_q & ~clk_s3_q;

  // ************************************************
  // nrzi to nrz: a transition is a one
  // ************************************************
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      nrzi_q  <= 1'b0;
      nrz_q   <= 1'b0;
      nrz_v_q <= 1'b0;
    end else begin
      nrz_v_q <= edge_w;
      if (edge_w) begin
        nrzi_q <= dat_s2_q;
        nrz_q  <= dat_s2_q ^ nrzi_q;
      end
    end
  end

  // ************************************************
  // descrambler and bypass routing
  // ************************************************
  assign byp_dsc = descr_bypass_i | rx_bypass_i;
  assign byp_dec = dec_bypass_i | rx_bypass_i;

  fep_descrambler #(
    .HOLD_CYC (HOLD_CYC)
  ) u_dsc (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .bit_v_i   (nrz_v_q),
    .sd_i      (nrz_q),
    .bypass_i  (byp_dsc),
    .ud_o      (ud_w),
    .ud_v_o    (ud_v_w),
    .locked_o  (descr_locked_o)
  );

  // raw nrz goes straight on when the receiver is bypassed
  assign al_bit = rx_bypass_i ? nrz_q : ud_w;
  assign al_v   = rx_bypass_i ? nrz_v_q : ud_v_w;

  assign sh_n     = {sh_q[8:0], al_bit};
  assign sym_n    = sh_n[4:0];
  assign dec_n    = fep_dec(sym_n);
  assign sym_idle = (sym_n == `FEP_SYM_IDLE);

  // ************************************************
  // link integrity monitor
  // ************************************************
  assign sd_eff  = sd_s2_q | pcs_config_register_i[`FEP_CFG_FORCE_SD];
  assign lock_ok = ~pcs_config_register_i[`FEP_CFG_LOCK_REQ] |
                   descr_locked_o;

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      link_cnt_q <= 16'h0000;
      link_up_o  <= 1'b0;
    end else if (!sd_eff) begin
      // any loss restarts qualification
      link_cnt_q <= 16'h0000;
      link_up_o  <= 1'b0;
    end else if (!link_up_o) begin
      if (link_cnt_q < LINK_CYC - 16'h0001) begin
        link_cnt_q <= link_cnt_q + 16'h0001;
      end else if (lock_ok) begin
        link_up_o <= 1'b1;
      end
    end
  end

  assign tx_pcs_en_o = link_up_o;
  assign rx_pcs_en_o = link_up_o;

  // ************************************************
  // aligner, decoder and bad ssd detection
  // ************************************************
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sh_q                <= 10'h000;
      ones_q              <= 4'h0;
      st_q                <= ST_WAIT;
      cnt_q               <= 3'h0;
      ph_q                <= 3'h0;
      t_seen_q            <= 1'b0;
      idle1_q             <= 1'b0;
      pre2_q              <= 1'b0;
      rx_nib_o            <= 4'h0;
      rx_nib_v_o          <= 1'b0;
      rx_dv_o             <= 1'b0;
      rx_er_o             <= 1'b0;
      rx_sym_o            <= 5'h00;
      rx_sym_v_o          <= 1'b0;
      false_carrier_cnt_o <= 16'h0000;
      bad_ssd_rpt_o       <= 1'b0;
    end else begin
      // strobes default low each cycle
      rx_nib_v_o    <= 1'b0;
      rx_er_o       <= 1'b0;
      rx_sym_v_o    <= 1'b0;
      bad_ssd_rpt_o <= 1'b0;
      pre2_q        <= 1'b0;
      if (pre2_q && link_up_o) begin
        rx_nib_o   <= `FEP_NIB_PREAMBLE;
        rx_nib_v_o <= ~byp_dec;
        rx_sym_o   <= sh_q[4:0];
        rx_sym_v_o <= byp_dec;
      end
      if (!link_up_o) begin
        // receive pcs held off until link up
        st_q    <= ST_WAIT;
        rx_dv_o <= 1'b0;
      end else if (al_v) begin
        sh_q <= sh_n;
        if (!al_bit) begin
          ones_q <= 4'h0;
        end else if ({28'h0000000, ones_q} != `FEP_TWO_IDLE) begin
          ones_q <= ones_q + 4'h1;
        end
        ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
        case (st_q)
          ST_WAIT: begin
            if (al_bit && {28'h0000000, ones_q} >= `FEP_TWO_IDLE - 1) begin
              st_q <= ST_IDLE;
            end
          end
          ST_IDLE: begin
            // first zero after idles opens a start check
            if (!al_bit) begin
              st_q  <= ST_SSD;
              cnt_q <= 3'h0;
            end
          end
          ST_SSD: begin
            cnt_q <= cnt_q + 3'h1;
            if ({29'h00000000, cnt_q} == `FEP_SSD_TAIL - 1) begin
              ph_q     <= 3'h0;
              t_seen_q <= 1'b0;
              idle1_q  <= 1'b0;
              rx_dv_o  <= 1'b1;
              if (sh_n == `FEP_JK_PAIR) begin
                // start pair replaced by preamble
                st_q       <= ST_PKT;
                rx_nib_o   <= `FEP_NIB_PREAMBLE;
                rx_nib_v_o <= ~byp_dec;
                pre2_q     <= 1'b1;
                rx_sym_o   <= sh_n[9:5];
                rx_sym_v_o <= byp_dec;
              end else begin
                st_q                <= ST_BAD;
                false_carrier_cnt_o <= false_carrier_cnt_o + 16'h0001;
                rx_nib_o            <= `FEP_NIB_BADSSD;
                rx_nib_v_o          <= 1'b1;
                rx_er_o             <= 1'b1;
              end
            end
          end
          ST_PKT: begin
            if (ph_q == 3'h4) begin
              // a whole symbol on the fixed boundary
              idle1_q    <= sym_idle;
              rx_sym_o   <= sym_n;
              rx_sym_v_o <= byp_dec;
              t_seen_q   <= (sym_n == `FEP_SYM_T);
              if ((t_seen_q && sym_n == `FEP_SYM_R) ||
                  (idle1_q && sym_idle)) begin
                st_q    <= (idle1_q && sym_idle) ? ST_IDLE : ST_WAIT;
                rx_dv_o <= 1'b0;
              end else if (!byp_dec && !sym_idle &&
                           sym_n != `FEP_SYM_T) begin
                rx_nib_o   <= dec_n[3:0];
                rx_nib_v_o <= 1'b1;
                rx_er_o    <= dec_n[4];
              end
            end
          end
          ST_BAD: begin
            if (ph_q == 3'h4) begin
              idle1_q <= sym_idle;
              if (idle1_q && sym_idle) begin
                st_q          <= ST_IDLE;
                rx_dv_o       <= 1'b0;
                bad_ssd_rpt_o <= 1'b1;
              end else begin
                rx_nib_o   <= `FEP_NIB_BADSSD;
                rx_nib_v_o <= 1'b1;
                rx_er_o    <= 1'b1;
              end
            end
          end
          default: begin
            st_q <= ST_WAIT;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- tb/fep_link_peer.sv
// far-end transmitter model: scrambler, nrzi line and recovered line clock
`timescale 1ns/1ps
`default_nettype none

module fep_link_peer (
  // line side
  output var logic line_clk_o,
  output var logic line_data_o,
  // control
  input  wire logic scr_en_i
);
  // *****************
  // transmit sequence
  // *****************
  logic [10:0] lfsr_q = 11'h5A3;  // start state, any nonzero value

  initial begin
    line_clk_o  = 1'b0;
    line_data_o = 1'b0;
  end

  // one code-group, msb first; clock stands still between calls
  task automatic send_sym(input logic [4:0] sym);
    logic n;
    logic sd;
    for (int b = 4; b >= 0; b--) begin
      n = lfsr_q[10] ^ lfsr_q[8];
      lfsr_q = {lfsr_q[9:0], n};
      sd = sym[b] ^ (scr_en_i & n);
      if (sd) begin
        line_data_o = ~line_data_o;    // nrzi: a one toggles the line
      end
      #100 line_clk_o = 1'b1;          // data stable 100 ns each side
      #100 line_clk_o = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

//--- tb/fep_rx_pcs_properties.sv
// concurrent checks on the receive pcs ports
`timescale 1ns/1ps
`default_nettype none

module fep_rx_pcs_properties #(
  parameter [15:0] HOLD_CYC = 16'h70D0,
  parameter [15:0] LINK_CYC = 16'h3DB8
) (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  // line status and config
  input wire logic        signal_detect_i,
  input wire logic [15:0] pcs_config_register_i,
  // mac side
  input wire logic [3:0]  rx_nib_o,
  input wire logic        rx_nib_v_o,
  input wire logic        rx_dv_o,
  input wire logic        rx_er_o,
  // status
  input wire logic [15:0] false_carrier_cnt_o,
  input wire logic        bad_ssd_rpt_o,
  input wire logic        descr_locked_o,
  input wire logic        link_up_o,
  input wire logic        tx_pcs_en_o,
  input wire logic        rx_pcs_en_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  // *****************
  // helper counters
  // *****************
  logic [15:0] sd_run_q;    // cycles of detect or force held high
  logic [15:0] lock_run_q;  // cycles of lock held high

  // run lengths, saturating
  always @(posedge clk_sys_i) begin
    if (!reset_n_i || !(signal_detect_i | pcs_config_register_i[1]))
      sd_run_q <= 16'h0000;
    else if (sd_run_q != 16'hFFFF)
      sd_run_q <= sd_run_q + 16'h0001;
    if (!reset_n_i || !descr_locked_o)
      lock_run_q <= 16'h0000;
    else if (lock_run_q != 16'hFFFF)
      lock_run_q <= lock_run_q + 16'h0001;
  end

  // *****************
  // assertions
  // *****************
  a_pcs_en_follow: assert property (tx_pcs_en_o == link_up_o && rx_pcs_en_o == link_up_o)
    else $error("pcs enables differ from link state");
  a_link_wait: assert property ($rose(link_up_o) |-> sd_run_q >= LINK_CYC - 16'h0001)
    else $error("link up before detect time");
  a_link_prompt: assert property (
    sd_run_q > LINK_CYC + 16'h0008 && !pcs_config_register_i[8] |-> link_up_o)
    else $error("link not up after detect time");
  a_link_lock: assert property (
    $rose(link_up_o) && pcs_config_register_i[8] |-> descr_locked_o || $past(descr_locked_o))
    else $error("link up without lock");
  a_quiet_down: assert property ((!link_up_o)[*8] |-> !rx_nib_v_o && !rx_dv_o)
    else $error("receive activity while link down");
  a_err_nibble: assert property (
    rx_er_o |-> rx_nib_v_o && (rx_nib_o == 4'hE || rx_nib_o == 4'h0))
    else $error("error without proper nibble");
  a_nib_in_pkt: assert property (rx_nib_v_o |-> rx_dv_o)
    else $error("nibble outside packet");
  a_fc_step: assert property (
    $past(reset_n_i) && $changed(false_carrier_cnt_o)
    |-> false_carrier_cnt_o == $past(false_carrier_cnt_o) + 16'h0001 ##[0:2] rx_dv_o)
    else $error("false carrier count step wrong");
  a_rpt_single: assert property (bad_ssd_rpt_o |-> !rx_er_o ##1 !bad_ssd_rpt_o [*4])
    else $error("bad start report not a single pulse");
  a_hold_time: assert property (
    $fell(descr_locked_o) |-> $past(lock_run_q) >= HOLD_CYC - 16'h0002)
    else $error("lock dropped before hold time");

  // *****************
  // coverage
  // *****************
  c_link_up: cover property ($rose(link_up_o));
  c_bad_ssd: cover property (bad_ssd_rpt_o);
  c_lock_lost: cover property ($fell(descr_locked_o));
endmodule

bind fep_rx_pcs fep_rx_pcs_properties #(.HOLD_CYC(HOLD_CYC), .LINK_CYC(LINK_CYC)) u_props (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .signal_detect_i(signal_detect_i),
  .pcs_config_register_i(pcs_config_register_i), .rx_nib_o(rx_nib_o),
  .rx_nib_v_o(rx_nib_v_o), .rx_dv_o(rx_dv_o), .rx_er_o(rx_er_o),
  .false_carrier_cnt_o(false_carrier_cnt_o), .bad_ssd_rpt_o(bad_ssd_rpt_o),
  .descr_locked_o(descr_locked_o), .link_up_o(link_up_o),
  .tx_pcs_en_o(tx_pcs_en_o), .rx_pcs_en_o(rx_pcs_en_o));

`default_nettype wire

//--- tb/fep_rx_pcs_tb.sv
// self-checking bench for the receive pcs
`timescale 1ns/1ps
`default_nettype none
`include "fep_rx_map.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module fep_rx_pcs_tb;
  localparam [15:0] HOLD = 16'h07D0;  // shortened hold interval
  localparam [15:0] LINK = 16'h0032;  // shortened detect interval

  // *****************
  // bench signals
  // *****************
  logic        clk_sys   = 1'b0;
  logic        reset_n   = 1'b0;
  logic        sd        = 1'b0;
  logic [15:0] cfg       = 16'h0000;
  logic        descr_byp = 1'b0;
  logic        scr_en    = 1'b1;
  logic        dec_byp   = 1'b0;
  logic        rx_byp    = 1'b0;
  wire         sym_v;
  wire  [4:0]  sym;
  wire         line_clk, line_data, nib_v, dv, er, rpt, locked, link, tx_en, rx_en;
  wire  [3:0]  nib;
  wire  [15:0] fc;
  logic [15:0] fc0;
  int          n_fail = 0, samples_checked = 0, cyc = 0, n_rpt = 0;
  logic [4:0]  got_q[$], tx_q[$], exp_q[$], sym_q[$];
  logic [4:0]  data_tbl [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

  always #12.5 clk_sys = ~clk_sys;

  fep_link_peer u_peer (.line_clk_o(line_clk), .line_data_o(line_data), .scr_en_i(scr_en));

  fep_rx_pcs #(.HOLD_CYC(HOLD), .LINK_CYC(LINK)) u_dut (
    .clk_sys_i(clk_sys), .reset_n_i(reset_n), .rx_line_clk_i(line_clk),
    .rx_line_data_i(line_data), .signal_detect_i(sd), .pcs_config_register_i(cfg),
    .descr_bypass_i(descr_byp), .dec_bypass_i(dec_byp), .rx_bypass_i(rx_byp),
    .rx_nib_o(nib), .rx_nib_v_o(nib_v), .rx_dv_o(dv), .rx_er_o(er), .rx_sym_o(sym),
    .rx_sym_v_o(sym_v), .false_carrier_cnt_o(fc), .bad_ssd_rpt_o(rpt), .descr_locked_o(locked),
    .link_up_o(link), .tx_pcs_en_o(tx_en), .rx_pcs_en_o(rx_en));

  // *****************
  // monitor, timeout, helpers
  // *****************
  // collect {error, nibble} pairs and report pulses
  always @(posedge clk_sys) begin
    cyc++;
    if (nib_v === 1'b1) got_q.push_back({er, nib});
    if (sym_v === 1'b1) sym_q.push_back(sym);
    if (rpt === 1'b1) n_rpt++;
    if (cyc == 40000) begin
      n_fail++;
      wrap_up;
    end
  end

  task wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task idles(input int n);
    repeat (n) u_peer.send_sym(`FEP_SYM_IDLE);
  endtask

  // idles, the queued symbols, idles; then compare the nibbles seen
  task run_frame;
    got_q.delete();
    sym_q.delete();
    idles(4);
    foreach (tx_q[i]) u_peer.send_sym(tx_q[i]);
    idles(4);
    `CHK(got_q.size(), exp_q.size())
    foreach (exp_q[i]) if (i < got_q.size()) `CHK(got_q[i], exp_q[i])
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // *****************
  // test sequence
  // *****************
  initial begin
    wait_clk(16);
    reset_n = 1'b1;
    wait_clk(100);
    `CHK(link, 1'b0)
    `CHK(fc, 16'h0000)
    cfg = 16'h0002;
    wait_clk(LINK + 10);
    `CHK(link, 1'b1)
    `CHK(rx_en, 1'b1)
    cfg = 16'h0000;
    wait_clk(10);
    `CHK(link, 1'b0)
    sd = 1'b1;
    wait_clk(LINK + 10);
    `CHK(tx_en, 1'b1)
    $display("test link done");
    sd = 1'b0;
    wait_clk(10);
    cfg = 16'h0100;
    sd = 1'b1;
    wait_clk(LINK + 20);
    `CHK(link, 1'b0)
    idles(11);
    `CHK(locked, 1'b0)
    idles(5);
    wait_clk(10);
    `CHK(locked, 1'b1)
    wait_clk(LINK);
    `CHK(link, 1'b1)
    cfg = 16'h0000;
    $display("test lock done");
    for (int m = 0; m < 2; m++) begin
      descr_byp = m[0];
      scr_en = ~m[0];
      tx_q = '{5'h18, 5'h11};
      exp_q = '{5'h05, 5'h05};
      for (int d = 0; d < 16; d++) begin
        tx_q.push_back(data_tbl[d]);
        exp_q.push_back(d[4:0]);
      end
      tx_q.push_back(`FEP_SYM_T);
      tx_q.push_back(`FEP_SYM_R);
      run_frame;
      `CHK(dv, 1'b0)
    end
    // raw code-groups on the symbol port, no nibbles, in both bypass routes
    scr_en = 1'b0;
    for (int m = 0; m < 2; m++) begin
      rx_byp = ~m[0];
      dec_byp = m[0];
      descr_byp = m[0];
      tx_q = '{5'h18, 5'h11, 5'h0F, `FEP_SYM_T, `FEP_SYM_R};
      exp_q.delete();
      run_frame;
      `CHK(sym_q.size(), 5)
      foreach (sym_q[i]) if (i < 5) `CHK(sym_q[i], tx_q[i])
      `CHK(dv, 1'b0)
    end
    rx_byp = 1'b0;
    dec_byp = 1'b0;
    $display("test bypass done");
    descr_byp = 1'b0;
    scr_en = 1'b1;
    idles(16);
    `CHK(locked, 1'b1)
    tx_q = '{5'h18, 5'h11, 5'h0F, 5'h00};
    exp_q = '{5'h05, 5'h05, 5'h07, 5'h10};
    run_frame;
    `CHK(dv, 1'b0)
    $display("test frames done");
    fc0 = fc;
    n_rpt = 0;
    tx_q = '{5'h1A, 5'h0B, 5'h04};
    exp_q = '{5'h1E, 5'h1E, 5'h1E};
    run_frame;
    `CHK(fc, fc0 + 16'h0001)
    `CHK(n_rpt, 1)
    $display("test bad start done");
    idles(60);
    `CHK(locked, 1'b1)
    repeat (60) u_peer.send_sym(5'h14);
    `CHK(locked, 1'b0)
    idles(16);
    wait_clk(10);
    `CHK(locked, 1'b1)
    $display("test hold done");
    wrap_up;
  end
endmodule

`default_nettype wire
